// *** adcc_pkg.sv ***
package adcc_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CLK_DIV   = 8'hf2;  // converter_clock_divider
    localparam logic [7:0] IDX_CONTROL   = 8'hf3;  // converter_control
    localparam logic [7:0] IDX_RES_LOW   = 8'hf4;  // result_low_byte
    localparam logic [7:0] IDX_RES_HIGH  = 8'hf5;  // result_high_byte
    localparam logic [7:0] IDX_PIN_CFG   = 8'hf6;  // channel_pin_config
    localparam logic [7:0] IDX_IRQ_EN    = 8'hf7;  // irq_enable_second

    // Field positions in converter_control, irq_enable_second and converter_clock_divider
    localparam int CTL_CH_LSB    = 0;
    localparam int CTL_CH_MSB    = 2;
    localparam int CTL_START_BIT = 3;
    localparam int CTL_DONE_BIT  = 4;
    localparam int CTL_EN_BIT    = 5;
    localparam int CTL_QUIET_BIT = 6;
    localparam int IRQ_EN_BIT    = 1;  // converter_irq_enable
    localparam int DIV_MSB       = 4;  // clock_divisor is bits 4..0

    // Widths, reset values and counts
    localparam int         ADDR_W        = 12;
    localparam int         RESULT_W      = 10;
    localparam int         DIV_W         = 5;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [3:0] CONV_TICKS    = 4'hb;   // sample period plus ten bit steps
    localparam logic [6:0] ZERO_DIV_LEN  = 7'h40;  // divisor zero divides by 64
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'b001,
        SEQ_SAMPLE = 3'b010,
        SEQ_BITS   = 3'b100
    } adcc_seq_type;

    // Signals toward the analog core
    typedef struct packed {
        logic                sample_hold;  // High during sample period
        logic [RESULT_W-1:0] trial_code;   // Trial level for comparator
        logic [2:0]          channel;      // Multiplexer select
    } adcc_core_type;

    // Peripheral clocks per converter clock period
    function automatic logic [6:0] div_period(input logic [DIV_W-1:0] divisor);
        div_period = (divisor == '0) ? ZERO_DIV_LEN : {1'b0, divisor, 1'b0};
    endfunction

endpackage

// *** adcc_prescaler.sv ***
`timescale 1ns/1ps
module adcc_prescaler (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      run,      // Count only while converting
    input  wire logic [adcc_pkg::DIV_W-1:0] divisor,
    output logic                           tick      // One converter clock edge
);
    import adcc_pkg::*;

    logic [6:0] cnt_ff;   // Peripheral cycles in current period
    logic       wrap;     // Last cycle of period

    assign wrap = (cnt_ff == 7'(div_period(divisor) - 7'h01));

    // Period counter; restarts each conversion so ticks are aligned to start
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_ff <= '0;
        end else if (wrap) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 7'h01;
        end
    end

    // Registered tick, high one cycle per converter period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 1'b0;
        end else begin
            tick <= run && wrap;
        end
    end

endmodule // adcc_prescaler

// *** adcc_sequencer.sv ***
`timescale 1ns/1ps
module adcc_sequencer (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          start,        // Accepted launch
    input  wire logic [2:0]                    channel,      // Channel at launch
    input  wire logic                          abort,        // Standby entered
    input  wire logic                          tick,         // Converter clock edge
    input  wire logic                          sample_above, // Comparator from core
    output logic                               busy,
    output logic                               finish,       // Last bit decided
    output logic [adcc_pkg::RESULT_W-1:0]      result,
    output adcc_pkg::adcc_core_type            core
);
    import adcc_pkg::*;

    adcc_seq_type        state_ff;  // Conversion phase
    logic [3:0]          idx_ff;    // Bit under trial
    logic [RESULT_W-1:0] sar_ff;    // Decided bits plus trial bit
    logic [2:0]          ch_ff;     // Latched channel

    assign busy   = (state_ff != SEQ_IDLE);
    assign finish = (state_ff == SEQ_BITS) && tick && (idx_ff == 4'h0);
    assign core   = '{sample_hold: (state_ff == SEQ_SAMPLE), trial_code: sar_ff, channel: ch_ff};

    // Phase control: one sample period then ten bit periods
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= SEQ_IDLE;
        end else begin
            unique case (state_ff)
                SEQ_IDLE: begin
                    if (start) state_ff <= SEQ_SAMPLE;
                end
                SEQ_SAMPLE: begin
                    if (abort) state_ff <= SEQ_IDLE;
                    else if (tick) state_ff <= SEQ_BITS;
                end
                SEQ_BITS: begin
                    if (abort || finish) state_ff <= SEQ_IDLE;
                end
                default: state_ff <= SEQ_IDLE;  // Illegal code recovers
            endcase
        end
    end

    // Channel held fixed for the whole conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_ff <= '0;
        end else if (state_ff == SEQ_IDLE && start) begin
            ch_ff <= channel;
        end
    end

    // Successive approximation: all-above gives full scale, none gives zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sar_ff <= '0;
            idx_ff <= '0;
        end else if (state_ff == SEQ_IDLE && start) begin
            sar_ff <= '0;
            idx_ff <= 4'(RESULT_W - 1);
        end else if (state_ff == SEQ_SAMPLE && tick) begin
            sar_ff <= {1'b1, {(RESULT_W-1){1'b0}}};
            idx_ff <= 4'(RESULT_W - 1);
        end else if (state_ff == SEQ_BITS && tick) begin
            sar_ff[idx_ff] <= sample_above;
            if (idx_ff != 4'h0) begin
                sar_ff[4'(idx_ff - 4'h1)] <= 1'b1;
                idx_ff                    <= 4'(idx_ff - 4'h1);
            end
        end
    end

    // Result loads on the same edge that busy falls at conversion end; an abort leaves it unchanged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= '0;
        end else if (finish) begin
            result <= {sar_ff[RESULT_W-1:1], sample_above};
        end
    end

endmodule // adcc_sequencer

// *** adcc_top.sv ***
`timescale 1ns/1ps
module adcc_top (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [adcc_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [adcc_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic                         sample_above,
    output adcc_pkg::adcc_core_type           core,
    output logic                              converter_standby,
    output logic [7:0]                        pin_converter_select,
    output logic                              converter_irq_source,
    output logic                              cpu_idle_request,
    output logic                              other_irq_hold,
    output logic                              cpu_wake
);
    import adcc_pkg::*;

    // Word index of a byte address
    function automatic logic [ADDR_W-3:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = addr[ADDR_W-1:2];
    endfunction

    // Whether an index names a register
    function automatic logic is_mapped(input logic [ADDR_W-3:0] idx);
        is_mapped = (idx >= (ADDR_W-2)'(IDX_CLK_DIV)) && (idx <= (ADDR_W-2)'(IDX_IRQ_EN));
    endfunction

    // Bus slave state
    logic [ADDR_W-1:0] awaddr_ff;   // Held write address
    logic              aw_held_ff;  // Address taken, waiting for data
    logic [7:0]        wbyte_ff;    // Held low data byte
    logic              wlane_ff;    // Low byte lane enabled
    logic              w_held_ff;   // Data taken, waiting for address
    logic              wr_fire;     // Both halves present, perform write
    logic [ADDR_W-3:0] wr_idx;

    // Software-visible registers, then internal launch and wake registers
    logic [DIV_W-1:0]    divisor_ff;  // clock_divisor
    logic [2:0]          ch_ff;       // channel_select
    logic                done_ff;     // conversion_done_flag
    logic                enable_ff;   // converter_enable
    logic                quiet_ff;    // quiet_idle_select
    logic [7:0]          pin_cfg_ff;  // channel_pin_config
    logic                irq_en_ff;   // converter_irq_enable
    logic                quiet_run_ff; // Quiet mode latched at launch
    logic                wake_ff;     // Wake pulse register

    // Conversion signals
    logic                ctl_wr;      // Control register write
    logic                start_req;   // Write carries start bit
    logic                start_ok;    // Launch accepted
    logic                busy;
    logic                finish;
    logic                tick;
    logic [RESULT_W-1:0] result;

    assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_idx  = word_index(awaddr_ff);
    assign ctl_wr  = wr_fire && wlane_ff && (wr_idx == (ADDR_W-2)'(IDX_CONTROL));

    // Handshake readies: one write and one read in flight
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Write address channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end
    end

    // Write data channel capture; only the low byte carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wbyte_ff  <= RST_BYTE;
            wlane_ff  <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wbyte_ff  <= s_axi_wdata[7:0];
            wlane_ff  <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Divider, pin config and irq enable writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divisor_ff <= '0;
            pin_cfg_ff <= RST_BYTE;
            irq_en_ff  <= 1'b0;
        end else if (wr_fire && wlane_ff) begin
            // Reserved bits are dropped; software must leave them zero
            if (wr_idx == (ADDR_W-2)'(IDX_CLK_DIV)) divisor_ff <= wbyte_ff[DIV_MSB:0];
            if (wr_idx == (ADDR_W-2)'(IDX_PIN_CFG)) pin_cfg_ff <= wbyte_ff;
            if (wr_idx == (ADDR_W-2)'(IDX_IRQ_EN))  irq_en_ff  <= wbyte_ff[IRQ_EN_BIT];
        end
    end

    // Control fields; the channel may change mid-conversion, the latched copy rules
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_ff     <= '0;
            enable_ff <= 1'b0;
            quiet_ff  <= 1'b0;
        end else if (ctl_wr) begin
            ch_ff     <= wbyte_ff[CTL_CH_MSB:CTL_CH_LSB];
            enable_ff <= wbyte_ff[CTL_EN_BIT];
            quiet_ff  <= wbyte_ff[CTL_QUIET_BIT];
        end
    end

    // Launch needs enable and a pin routed to the converter
    assign start_req = ctl_wr && wbyte_ff[CTL_START_BIT];
    assign start_ok  = start_req && !busy && wbyte_ff[CTL_EN_BIT]
                       && pin_cfg_ff[wbyte_ff[CTL_CH_MSB:CTL_CH_LSB]];

    // Done flag: hardware sets, software writes zero to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_ff <= 1'b0;
        end else if (finish) begin
            done_ff <= 1'b1;
        end else if (ctl_wr && !wbyte_ff[CTL_DONE_BIT]) begin
            done_ff <= 1'b0;
        end
    end

    // Quiet mode latched at launch so later writes cannot wake the cpu early
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quiet_run_ff <= 1'b0;
        end else if (start_ok) begin
            quiet_run_ff <= wbyte_ff[CTL_QUIET_BIT];
        end
    end

    // Wake pulse only from conversion end in quiet mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= finish && quiet_run_ff;
        end
    end

    // Read channel; reserved bits read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_mapped(word_index(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
            unique case (word_index(s_axi_araddr))
                (ADDR_W-2)'(IDX_CLK_DIV):  s_axi_rdata <= {27'h000_0000, divisor_ff};
                (ADDR_W-2)'(IDX_CONTROL):  s_axi_rdata <= {25'h000_0000, quiet_ff, enable_ff,
                                                           done_ff, busy, ch_ff};
                (ADDR_W-2)'(IDX_RES_LOW):  s_axi_rdata <= {30'h0000_0000, result[1:0]};
                (ADDR_W-2)'(IDX_RES_HIGH): s_axi_rdata <= {24'h00_0000, result[9:2]};
                (ADDR_W-2)'(IDX_PIN_CFG):  s_axi_rdata <= {24'h00_0000, pin_cfg_ff};
                (ADDR_W-2)'(IDX_IRQ_EN):   s_axi_rdata <= {30'h0000_0000, irq_en_ff, 1'b0};
                default:                   s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Converter clock; aclk is the peripheral clock, already cpu/2 in normal mode
    adcc_prescaler u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (busy),
        .divisor (divisor_ff),
        .tick    (tick)
    );

    // Conversion sequencer; clearing enable aborts into standby
    adcc_sequencer u_sequencer (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .start        (start_ok),
        .channel      (wbyte_ff[CTL_CH_MSB:CTL_CH_LSB]),
        .abort        (!enable_ff),
        .tick         (tick),
        .sample_above (sample_above),
        .busy         (busy),
        .finish       (finish),
        .result       (result),
        .core         (core)
    );

    // Outputs toward core, pins and cpu
    assign converter_standby    = !enable_ff;
    assign pin_converter_select = pin_cfg_ff;
    assign converter_irq_source = done_ff && irq_en_ff;
    assign cpu_idle_request     = busy && quiet_run_ff;
    assign other_irq_hold       = busy && quiet_run_ff;
    assign cpu_wake             = wake_ff;

    // Helper counters for checks
    logic [3:0] tick_cnt_ff;  // Ticks seen this conversion
    logic [6:0] gap_ff;       // Cycles since last tick
    always_ff @(posedge aclk) begin
        if (!aresetn || !busy) begin
            tick_cnt_ff <= '0;
            gap_ff      <= '0;
        end else if (tick) begin
            tick_cnt_ff <= tick_cnt_ff + 4'h1;
            gap_ff      <= 7'h01;
        end else begin
            gap_ff      <= gap_ff + 7'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_conv_eleven_ticks: assert property (finish |-> tick && tick_cnt_ff == 4'(CONV_TICKS - 4'h1))
        else $error("conversion did not take eleven periods");
    a_start_launches: assert property (start_ok |=> busy && core.channel == $past(wbyte_ff[CTL_CH_MSB:CTL_CH_LSB]))
        else $error("accepted start did not launch");
    a_busy_until_end: assert property (busy && enable_ff && !finish |=> busy)
        else $error("busy fell before conversion end");
    a_done_sticky: assert property (done_ff && !ctl_wr |=> done_ff)
        else $error("done flag cleared without software");
    a_irq_on_done: assert property (finish && irq_en_ff |=> converter_irq_source)
        else $error("interrupt missing after done");
    a_divider_gap: assert property (busy && tick |-> gap_ff == div_period(divisor_ff))
        else $error("converter clock period wrong");
    a_standby_out: assert property (ctl_wr && !wbyte_ff[CTL_EN_BIT] |=> converter_standby ##1 !busy)
        else $error("standby not entered");
    a_unconfig_ignored: assert property (start_req && !busy
        && !pin_cfg_ff[wbyte_ff[CTL_CH_MSB:CTL_CH_LSB]] |=> !busy)
        else $error("start on unrouted pin launched");
    // A restart would reload the channel or reopen the sample period without a tick
    a_no_restart: assert property (busy && start_req |=> !busy || (core.channel == $past(core.channel)
        && tick_cnt_ff == 4'($past(tick_cnt_ff) + 4'($past(tick))) && !$rose(core.sample_hold)))
        else $error("running conversion restarted");
    a_same_edge: assert property ($fell(busy) && enable_ff |-> done_ff && $changed(tick_cnt_ff))
        else $error("flag and busy did not change together");
    a_wake_end: assert property (finish && quiet_run_ff |=> cpu_wake ##1 !cpu_wake)
        else $error("wake pulse wrong");

    c_plain_conv: cover property (start_ok && !wbyte_ff[CTL_QUIET_BIT] ##[1:1000] finish);
    c_quiet_conv: cover property (cpu_idle_request ##[1:1000] cpu_wake);
    c_clear_race: cover property (finish && ctl_wr);

endmodule // adcc_top

// *** adcc_core_model.sv ***
`timescale 1ns/1ps
// Behavioural analog core: holds the selected level and compares it with the trial code
module adcc_core_model (
    input  wire logic                    aclk,
    input  wire adcc_pkg::adcc_core_type core,
    input  wire logic [79:0]             levels,       // Ten-bit level for each input
    output logic                         sample_above
);
    import adcc_pkg::*;
    logic [9:0] held_ff;  // Level frozen when the sample period ends
    // Follow the selected input only while sampling, so later mux changes cannot leak in
    always_ff @(posedge aclk) begin
        if (core.sample_hold) begin
            held_ff <= levels[core.channel*10 +: 10];
        end
    end
    // Comparator; codes saturate at 000h and 3FFh by construction
    assign sample_above = (held_ff >= core.trial_code);
endmodule // adcc_core_model

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb_top;
    import adcc_pkg::*;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, above, stby, irq, idle, hold, wake, sh_q, irq_q;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [1:0]  bresp, rresp, bs, rs;
    logic [7:0]  rd, pins;
    logic [79:0] lv;
    logic [9:0]  last;
    adcc_core_type core;
    int          err_count = 0, n_tests = 0, seed = 70557, cyc = 0, t_start = 0, t_done = 0;
    always #25 aclk = ~aclk;
    adcc_top u_adcc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sample_above(above), .core(core), .converter_standby(stby),
        .pin_converter_select(pins), .converter_irq_source(irq), .cpu_idle_request(idle),
        .other_irq_hold(hold), .cpu_wake(wake));
    adcc_core_model u_adcc_core_model (.aclk(aclk), .core(core), .levels(lv), .sample_above(above));
    // Timestamps of sample start and interrupt rise, taken on settled values
    always @(negedge aclk) begin
        cyc++;
        if (core.sample_hold && !sh_q) t_start = cyc;
        if (irq && !irq_q) t_done = cyc;
        sh_q = core.sample_hold;
        irq_q = irq;
    end
    // Verdict and counts, the single exit point
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Handshakes judged at the falling edge, released right after the rising one
    task automatic axw(input logic [7:0] idx, input logic [7:0] d);
        int  n;
        logic a, w, b;
        n = 0;
        @(posedge aclk);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(negedge aclk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            bs = bresp;
            @(posedge aclk);
            if (a) awvalid <= 0;
            if (w) wvalid <= 0;
            n++;
        end while (!b && n < 100);
        bready <= 0;
        if (n >= 100) begin err_count++; end_of_test(); end
    endtask
    task automatic axr(input logic [7:0] idx);
        int  n;
        logic a, r;
        n = 0;
        @(posedge aclk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        do begin
            @(negedge aclk);
            a = arvalid && arready;
            r = rvalid;
            rd = rdata[7:0];
            rs = rresp;
            @(posedge aclk);
            if (a) arvalid <= 0;
            n++;
        end while (!r && n < 100);
        rready <= 0;
        if (n >= 100) begin err_count++; end_of_test(); end
    endtask
    // Expected length: eleven converter periods plus the one-cycle delay of the registered tick
    function automatic int exp_len(input logic [4:0] d);
        return 11 * ((d == 5'h00) ? 64 : 2 * d) + 1;
    endfunction
    // One conversion with a restart attempt while busy, then flag handling
    task automatic conv(input logic [2:0] ch, input logic [7:0] mode, input logic [4:0] dv);
        int  n;
        logic [2:0] ch2;
        ch2 = ch + 3'h1;
        last = lv[ch*10 +: 10];
        axw(IDX_CLK_DIV, {3'b000, dv});
        axw(IDX_CONTROL, mode | {5'h00, ch});
        @(negedge aclk);
        `CHK("idle", mode[6], idle)
        `CHK("hold", mode[6], hold)
        axw(IDX_CONTROL, mode | {5'h00, ch2});
        `CHK("mux", ch, core.channel)
        axr(IDX_CONTROL);
        `CHK("busy", 1'b1, rd[3])
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin @(negedge aclk); n++; end
        if (n >= 2000) begin err_count++; end_of_test(); end
        `CHK("wake", mode[6], wake)
        @(negedge aclk);
        `CHK("len", exp_len(dv), t_done - t_start)
        axr(IDX_RES_HIGH);
        `CHK("res_hi", last[9:2], rd)
        axr(IDX_RES_LOW);
        `CHK("res_lo", {6'h00, last[1:0]}, rd)
        axr(IDX_CONTROL);
        `CHK("ctl_done", (mode & 8'h60) | 8'h10 | {5'h00, ch2}, rd)
        axw(IDX_CONTROL, 8'h30);
        `CHK("irq_on", 1'b1, irq)
        axw(IDX_CONTROL, 8'h20);
        `CHK("irq_off", 1'b0, irq)
        $display("test conversion ch %0d done", ch);
    endtask
    initial begin
        for (int i = 0; i < 8; i++) lv[i*10 +: 10] = 10'($random(seed));
        lv[19:0] = {10'h000, 10'h3ff};
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        `CHK("standby", 1'b1, stby)
        for (int i = 0; i < 6; i++) begin axr(8'(8'hf2 + i)); `CHK("reset", 8'h00, rd) end
        axr(8'h10);
        `CHK("rd_unmapped", RESP_SLVERR, rs)
        axw(8'h10, 8'hff);
        `CHK("wr_unmapped", RESP_SLVERR, bs)
        axw(IDX_PIN_CFG, 8'hff);
        `CHK("pins", 8'hff, pins)
        axw(IDX_IRQ_EN, 8'h02);
        axw(IDX_CONTROL, 8'h20);
        `CHK("awake", 1'b0, stby)
        repeat (20) @(posedge aclk); // Settling time after enable, before the first start
        $display("test registers done");
        for (int c = 0; c < 8; c++) conv(3'(c), c[0] ? 8'h68 : 8'h28, (c == 2) ? 5'h00 : 5'($random(seed)) | 5'h02);
        axw(IDX_PIN_CFG, 8'hf7);
        axw(IDX_CONTROL, 8'h2b);
        axr(IDX_CONTROL);
        `CHK("unrouted", 8'h23, rd)
        axw(IDX_PIN_CFG, 8'hff);
        axw(IDX_CLK_DIV, 8'h00);
        axw(IDX_CONTROL, 8'h2c);
        axw(IDX_CONTROL, 8'h00);
        repeat (exp_len(5'h00)) @(posedge aclk);
        axr(IDX_CONTROL);
        `CHK("abort", 8'h00, rd)
        axr(IDX_RES_HIGH);
        `CHK("abort_res", last[9:2], rd)
        $display("test standby and unrouted done");
        end_of_test();
    end
endmodule // tb_top
